// ==== logic/aoic_pkg.sv ====
`default_nettype none
package aoic_pkg;
   localparam int SAMPLE_W = 12;
   localparam int FRAME_W = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // Register offsets
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_SPEED_TUNING_A = 8'h02;
   localparam logic [7:0] ADDR_PERFORMANCE_TUNING = 8'h03;
   localparam logic [7:0] ADDR_HF_INPUT_CHAN_A = 8'h4a;
   localparam logic [7:0] ADDR_HF_INPUT_CHAN_B = 8'h58;
   localparam logic [7:0] ADDR_SPEED_TUNING_B = 8'hd5;
   localparam logic [7:0] ADDR_SPEED_TUNING_C = 8'hd7;
   localparam logic [7:0] ADDR_SPEED_TUNING_D = 8'hdb;
   localparam logic [7:0] ADDR_OUTPUT_CFG = 8'h41;
   localparam logic [7:0] ADDR_POWER_MODE = 8'h42;
   // Field positions
   localparam int CONTROL_RESET_BIT = 1;
   localparam int CONTROL_READOUT_BIT = 0;
   localparam int OUTPUT_CFG_DDR_BIT = 0;
   localparam int POWER_MODE_W = 3;
   localparam int HF_ENABLE_BIT = 0;
   // Reset values
   localparam logic [7:0] REG_RESET_VALUE = 8'h00;
   // Power-mode codes, same order as {pin one, pin two, pin three}
   localparam logic [2:0] PMODE_NORMAL = 3'h0;
   localparam logic [2:0] PMODE_GLOBAL_PD = 3'h4;
   localparam logic [2:0] PMODE_CHAN_A_STANDBY = 3'h5;
   localparam logic [2:0] PMODE_MUX = 3'h7;
   // Recommended high-speed register values
   localparam logic [7:0] HS_VALUE_A = 8'h40;
   localparam logic [7:0] HS_VALUE_B = 8'h18;
   localparam logic [7:0] HS_VALUE_C = 8'h0c;
   localparam logic [7:0] HS_VALUE_D = 8'h20;
   // Output clock period in sampling-clock cycles: one phase per edge kind
   localparam int OUT_PHASES = 2;
   localparam int BUF_DEPTH_DEFAULT = 2;
endpackage
`default_nettype wire

// ==== logic/aoic_top.sv ====
// Notes on behaviour
// - Each conversion gives a 12-bit word per channel plus a synchronous output clock.
// - DDR or parallel CMOS chosen by register bit, or by select pin level.
// - DDR mode carries two sample bits per pair per output clock period.
// - DDR: even bits with positive clock high, odd bits with it low.
// - CMOS mode drives each bit on its own pin, one word per period.
// - Multiplexed mode interleaves both channels onto the channel B bus.
// - Multiplexed mode keeps all channel A pins high impedance.
// - Multiplexed mode entered from power-mode field or the three control pins.
// - Parallel configuration needs no reset pulse and ignores serial data.
// - Parallel mode: clock pin low-speed, select pin interface, control pins power.
// - Serial mode: select, data, clock pins form a register write port.
// - Reset pin pulse or reset register bit restores all register defaults.
// - Frame of 16 bits, address then data, loaded on sixteenth fall.
// - Serial data sampled on serial clock falling edges while select low.
// - All control pins high gives mux; only first high gives power-down.
// - Reset register bit clears itself after the registers initialise.
`default_nettype none
module aoic_top #(
   parameter int BUF_DEPTH = aoic_pkg::BUF_DEPTH_DEFAULT
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic reset_pin,
   input wire logic serial_select_pin,
   input wire logic serial_clock_pin,
   input wire logic serial_data_in_pin,
   input wire logic power_ctl_pin_one,
   input wire logic power_ctl_pin_two,
   input wire logic power_ctl_pin_three,
   input wire logic [aoic_pkg::SAMPLE_W-1:0] chan_a_sample,
   input wire logic [aoic_pkg::SAMPLE_W-1:0] chan_b_sample,
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic rx_ready,
   output logic [aoic_pkg::SAMPLE_W-1:0] chan_a_out_bus,
   output logic [aoic_pkg::SAMPLE_W-1:0] chan_a_out_oe,
   output logic [aoic_pkg::SAMPLE_W-1:0] chan_b_out_bus,
   output logic [aoic_pkg::SAMPLE_W-1:0] chan_b_out_oe,
   output logic out_clock_positive,
   output logic out_clock_single,
   output logic word_fresh,
   output logic ddr_active,
   output logic mux_active,
   output logic global_power_down,
   output logic low_speed_mode,
   output logic [1:0] best_performance_bits,
   output logic hf_input_chan_a,
   output logic hf_input_chan_b,
   output logic high_speed_mode
);
   localparam int SW = aoic_pkg::SAMPLE_W;
   localparam int HALF = SW / 2;
   localparam int PW = $clog2(BUF_DEPTH);
   localparam int CW = $clog2(BUF_DEPTH + 1);

   if (BUF_DEPTH != 2)
   begin : g_bad_depth
      $error("BUF_DEPTH must be 2; pointer logic assumes a power of two of two");
   end

   // Two-flop synchronisers for every pin
   logic [5:0] pin_s1_reg;
   logic [5:0] pin_s2_reg;
   logic sclk_prev_reg;
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         pin_s1_reg <= 6'h00;
         pin_s2_reg <= 6'h00;
         sclk_prev_reg <= 1'b0;
      end
      else
      begin
         pin_s1_reg <= {reset_pin, serial_select_pin, serial_clock_pin, serial_data_in_pin,
                        power_ctl_pin_one, power_ctl_pin_two};
         pin_s2_reg <= pin_s1_reg;
         sclk_prev_reg <= pin_s2_reg[3];
      end
   end
   logic [2:0] ctl_s1_reg;
   logic [2:0] ctl_s2_reg;
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         ctl_s1_reg <= 3'h0;
         ctl_s2_reg <= 3'h0;
      end
      else
      begin
         ctl_s1_reg <= {pin_s2_reg[1], pin_s2_reg[0], power_ctl_pin_three};
         ctl_s2_reg <= ctl_s1_reg;
      end
   end
   // Pin three gets its own pair; one and two are already twice registered above
   logic [2:0] ctl_pins;
   assign ctl_pins = {pin_s2_reg[1], pin_s2_reg[0], ctl_s2_reg[0]};

   logic par_mode;
   logic sen_s;
   logic sclk_s;
   logic serial_data_in_pin_s;
   logic sclk_fall;
   assign par_mode = pin_s2_reg[5];
   assign sen_s = pin_s2_reg[4];
   assign sclk_s = pin_s2_reg[3];
   assign serial_data_in_pin_s = pin_s2_reg[2];
   assign sclk_fall = sclk_prev_reg && !sclk_s;

   // Serial frame shifter; held cleared in parallel mode, so serial frames are ignored there
   logic [aoic_pkg::FRAME_W-2:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic frame_done;
   logic [aoic_pkg::FRAME_W-1:0] frame;
   assign frame = {shift_reg, serial_data_in_pin_s};
   assign frame_done = sclk_fall && !sen_s && !par_mode && bit_cnt_reg == 4'hf;
   always_ff @(posedge mclk)
   begin
      if (!rst_n || sen_s || par_mode)
      begin
         shift_reg <= '0;
         bit_cnt_reg <= 4'h0;
      end
      else if (sclk_fall)
      begin
         shift_reg <= frame[aoic_pkg::FRAME_W-2:0];
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
   end
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   assign wr_addr = frame[15:8];
   assign wr_data = frame[7:0];

   // Register file; reset pin high, either as pulse or held, forces defaults
   logic [7:0] control_reg;
   logic [7:0] speed_tuning_a_reg;
   logic [7:0] performance_tuning_reg;
   logic [7:0] high_freq_input_chan_a_reg;
   logic [7:0] high_freq_input_chan_b_reg;
   logic [7:0] speed_tuning_b_reg;
   logic [7:0] speed_tuning_c_reg;
   logic [7:0] speed_tuning_d_reg;
   logic [7:0] output_cfg_reg;
   logic [7:0] power_mode_reg;
   logic regs_clear;
   logic wr_en;
   assign regs_clear = !rst_n || par_mode || control_reg[aoic_pkg::CONTROL_RESET_BIT];
   // Readback mode blocks writes except to the control register
   assign wr_en = frame_done
                  && (!control_reg[aoic_pkg::CONTROL_READOUT_BIT]
                      || wr_addr == aoic_pkg::ADDR_CONTROL);
   always_ff @(posedge mclk)
   begin
      if (regs_clear)
      begin
         control_reg <= aoic_pkg::REG_RESET_VALUE;
         speed_tuning_a_reg <= aoic_pkg::REG_RESET_VALUE;
         performance_tuning_reg <= aoic_pkg::REG_RESET_VALUE;
         high_freq_input_chan_a_reg <= aoic_pkg::REG_RESET_VALUE;
         high_freq_input_chan_b_reg <= aoic_pkg::REG_RESET_VALUE;
         speed_tuning_b_reg <= aoic_pkg::REG_RESET_VALUE;
         speed_tuning_c_reg <= aoic_pkg::REG_RESET_VALUE;
         speed_tuning_d_reg <= aoic_pkg::REG_RESET_VALUE;
         output_cfg_reg <= aoic_pkg::REG_RESET_VALUE;
         power_mode_reg <= aoic_pkg::REG_RESET_VALUE;
      end
      else if (wr_en)
      begin
         case (wr_addr)
            aoic_pkg::ADDR_CONTROL: control_reg <= {6'h00, wr_data[1:0]};
            aoic_pkg::ADDR_SPEED_TUNING_A: speed_tuning_a_reg <= wr_data;
            aoic_pkg::ADDR_PERFORMANCE_TUNING: performance_tuning_reg <= {6'h00, wr_data[1:0]};
            aoic_pkg::ADDR_HF_INPUT_CHAN_A: high_freq_input_chan_a_reg <= wr_data;
            aoic_pkg::ADDR_HF_INPUT_CHAN_B: high_freq_input_chan_b_reg <= wr_data;
            aoic_pkg::ADDR_SPEED_TUNING_B: speed_tuning_b_reg <= wr_data;
            aoic_pkg::ADDR_SPEED_TUNING_C: speed_tuning_c_reg <= wr_data;
            aoic_pkg::ADDR_SPEED_TUNING_D: speed_tuning_d_reg <= wr_data;
            aoic_pkg::ADDR_OUTPUT_CFG: output_cfg_reg <= {7'h00, wr_data[0]};
            aoic_pkg::ADDR_POWER_MODE: power_mode_reg <= {5'h00, wr_data[2:0]};
            default: ;
         endcase
      end
   end

   // Mode requests; ddr and mux wait for the sample-boundary latch, power-down and standby do not
   logic ddr_req;
   logic mux_req;
   logic pd_req;
   logic standby_req;
   logic [2:0] pmode;
   assign pmode = power_mode_reg[aoic_pkg::POWER_MODE_W-1:0];
   assign ddr_req = par_mode ? sen_s : output_cfg_reg[aoic_pkg::OUTPUT_CFG_DDR_BIT];
   assign mux_req = ctl_pins == aoic_pkg::PMODE_MUX || pmode == aoic_pkg::PMODE_MUX;
   assign pd_req = ctl_pins == aoic_pkg::PMODE_GLOBAL_PD
                   || pmode == aoic_pkg::PMODE_GLOBAL_PD;
   assign standby_req = ctl_pins == aoic_pkg::PMODE_CHAN_A_STANDBY
                        || pmode == aoic_pkg::PMODE_CHAN_A_STANDBY;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         global_power_down <= 1'b0;
         low_speed_mode <= 1'b0;
         best_performance_bits <= 2'h0;
         hf_input_chan_a <= 1'b0;
         hf_input_chan_b <= 1'b0;
         high_speed_mode <= 1'b0;
      end
      else
      begin
         global_power_down <= pd_req;
         low_speed_mode <= par_mode && sclk_s;
         best_performance_bits <= performance_tuning_reg[1:0];
         hf_input_chan_a <= high_freq_input_chan_a_reg[aoic_pkg::HF_ENABLE_BIT];
         hf_input_chan_b <= high_freq_input_chan_b_reg[aoic_pkg::HF_ENABLE_BIT];
         high_speed_mode <= speed_tuning_a_reg == aoic_pkg::HS_VALUE_A
                            && speed_tuning_b_reg == aoic_pkg::HS_VALUE_B
                            && speed_tuning_c_reg == aoic_pkg::HS_VALUE_C
                            && speed_tuning_d_reg == aoic_pkg::HS_VALUE_D;
      end
   end

   // Two-entry sample buffer; a stalled receiver holds words here
   logic [2*SW-1:0] buf_mem [BUF_DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic push;
   logic pop;
   logic boundary;
   logic phase_reg;
   assign boundary = phase_reg;
   assign push = sample_valid && sample_ready;
   assign pop = boundary && rx_ready && count_reg != '0;
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         sample_ready <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + CW'(push) - CW'(pop);
         sample_ready <= (count_reg + CW'(push) - CW'(pop)) < CW'(BUF_DEPTH);
      end
   end
   always_ff @(posedge mclk)
   begin
      if (push)
      begin
         buf_mem[wr_ptr_reg] <= {chan_a_sample, chan_b_sample};
      end
   end

   // Output engine: phase 0 is the clock-high half, phase 1 the low half
   logic [SW-1:0] word_a_reg;
   logic [SW-1:0] word_b_reg;
   // Fresh mark runs one stage ahead of the pins; delayed below to line up
   logic fresh_reg;
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         phase_reg <= 1'b1;
         word_a_reg <= '0;
         word_b_reg <= '0;
         ddr_active <= 1'b0;
         mux_active <= 1'b0;
         fresh_reg <= 1'b0;
      end
      else
      begin
         phase_reg <= !phase_reg;
         if (boundary)
         begin
            ddr_active <= ddr_req;
            mux_active <= mux_req;
            fresh_reg <= pop;
            if (pop)
            begin
               {word_a_reg, word_b_reg} <= buf_mem[rd_ptr_reg];
            end
         end
      end
   end

   // Pins follow one cycle behind the engine state
   logic [SW-1:0] a_next;
   logic [SW-1:0] b_next;
   logic [SW-1:0] a_oe_next;
   logic [SW-1:0] b_oe_next;
   logic pos_next;
   logic single_next;
   logic cur_phase;
   always_comb
   begin
      cur_phase = !phase_reg;
      a_next = '0;
      b_next = '0;
      a_oe_next = '1;
      b_oe_next = '1;
      pos_next = 1'b0;
      single_next = 1'b0;
      if (mux_active)
      begin
         a_oe_next = '0;
         b_next = cur_phase ? word_b_reg : word_a_reg;
         pos_next = !cur_phase;
         single_next = !cur_phase;
      end
      else if (ddr_active)
      begin
         for (int i = 0; i < HALF; i++)
         begin
            a_next[i] = word_a_reg[2*i + int'(cur_phase)];
            b_next[i] = word_b_reg[2*i + int'(cur_phase)];
         end
         a_oe_next[SW-1:HALF] = '0;
         b_oe_next[SW-1:HALF] = '0;
         pos_next = !cur_phase;
      end
      else
      begin
         a_next = word_a_reg;
         b_next = word_b_reg;
         // Rise falls mid-word so the receiver never latches on a changing bus
         single_next = !cur_phase;
      end
      // Standby silences channel A only; global power-down silences both buses, while the output clocks keep toggling
      if (standby_req)
      begin
         a_oe_next = '0;
      end
      if (pd_req)
      begin
         a_oe_next = '0;
         b_oe_next = '0;
      end
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         chan_a_out_bus <= '0;
         chan_b_out_bus <= '0;
         chan_a_out_oe <= '0;
         chan_b_out_oe <= '0;
         out_clock_positive <= 1'b0;
         out_clock_single <= 1'b0;
         word_fresh <= 1'b0;
      end
      else
      begin
         word_fresh <= fresh_reg;
         chan_a_out_bus <= a_next;
         chan_b_out_bus <= b_next;
         chan_a_out_oe <= a_oe_next;
         chan_b_out_oe <= b_oe_next;
         out_clock_positive <= pos_next;
         out_clock_single <= single_next;
      end
   end
endmodule
`default_nettype wire

// ==== test/aoic_asserts.sv ====
`default_nettype none
module aoic_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sample_ready,
   input wire logic [aoic_pkg::SAMPLE_W-1:0] chan_a_out_oe,
   input wire logic [aoic_pkg::SAMPLE_W-1:0] chan_b_out_bus,
   input wire logic [aoic_pkg::SAMPLE_W-1:0] chan_b_out_oe,
   input wire logic out_clock_positive,
   input wire logic out_clock_single,
   input wire logic word_fresh,
   input wire logic ddr_active,
   input wire logic mux_active,
   input wire logic global_power_down
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Modes held three cycles so the pins have caught up with the latch
   mux_hiz_a: assert property (mux_active [*3] |-> chan_a_out_oe == '0)
      else $error("channel A driven in mux mode");
   mux_bus_b_a: assert property ((mux_active && !global_power_down) [*3] |-> &chan_b_out_oe)
      else $error("channel B not driven in mux mode");
   pd_hiz_a: assert property (global_power_down [*3]
      |-> chan_a_out_oe == '0 && chan_b_out_oe == '0)
      else $error("pins driven in power-down");
   ddr_lanes_a: assert property ((ddr_active && !mux_active) [*3] |-> chan_b_out_oe[11:6] == '0)
      else $error("upper lanes driven in DDR mode");
   ddr_clock_a: assert property ((ddr_active && !mux_active && !global_power_down) [*3]
      |-> out_clock_positive != $past(out_clock_positive))
      else $error("DDR clock not toggling");
   cmos_clock_a: assert property ((!ddr_active && !mux_active && !global_power_down) [*3]
      |-> out_clock_single != $past(out_clock_single))
      else $error("CMOS clock not toggling");
   cmos_hold_a: assert property ((!ddr_active && !mux_active) [*2] ##0 $rose(out_clock_single)
      |-> $stable(chan_b_out_bus))
      else $error("CMOS word changed mid period");
   fresh_pair_a: assert property ($rose(word_fresh) |=> word_fresh)
      else $error("fresh word shorter than one period");
   mode_edge_a: assert property ($changed(ddr_active) |=> $stable(ddr_active))
      else $error("interface mode changed off boundary");
   reset_quiet_a: assert property ($rose(rst_n)
      |-> !sample_ready && !word_fresh && chan_b_out_oe == '0)
      else $error("outputs not cleared by reset");
   cover property (ddr_active && word_fresh);
   cover property (mux_active && word_fresh);
   cover property ($fell(sample_ready));
endmodule
bind aoic_top aoic_checker chk_u (.mclk, .rst_n, .sample_ready, .chan_a_out_oe, .chan_b_out_bus,
   .chan_b_out_oe, .out_clock_positive, .out_clock_single, .word_fresh, .ddr_active,
   .mux_active, .global_power_down);
`default_nettype wire

// ==== test/aoic_rx_model.sv ====
`default_nettype none
module aoic_rx_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic slow,
   output logic rx_ready,
   input wire logic word_fresh,
   input wire logic ddr_active,
   input wire logic mux_active,
   input wire logic out_clock_positive,
   input wire logic out_clock_single,
   input wire logic [11:0] chan_a_out_bus,
   input wire logic [11:0] chan_b_out_bus,
   output logic got_valid,
   output logic [11:0] got_a,
   output logic [11:0] got_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] lfsr_reg;
   logic half_reg;
   logic key;
   logic [11:0] hi_a_reg, hi_b_reg, lo_a_reg, lo_b_reg;
   function automatic logic [11:0] weave(input logic [5:0] ev, input logic [5:0] od);
      logic [11:0] w;
      for (int i = 0; i < 6; i++)
      begin
         w[2*i] = ev[i];
         w[2*i+1] = od[i];
      end
      return w;
   endfunction
   // Stalls about a fifth of the time (3 of 15 states) so the buffer fills
   assign rx_ready = !slow || lfsr_reg[0] || lfsr_reg[1];
   assign key = (ddr_active || mux_active) ? out_clock_positive : out_clock_single;
   always_ff @(posedge mclk)
   begin
      lfsr_reg <= rst_n ? {lfsr_reg[2:0], lfsr_reg[3] ^ lfsr_reg[2]} : 4'h9;
      half_reg <= rst_n && word_fresh && !half_reg;
      got_valid <= rst_n && word_fresh && ((ddr_active || mux_active) ? half_reg : key);
      if (word_fresh && key)
      begin
         hi_a_reg <= chan_a_out_bus;
         hi_b_reg <= chan_b_out_bus;
      end
      if (word_fresh && !key)
      begin
         lo_a_reg <= chan_a_out_bus;
         lo_b_reg <= chan_b_out_bus;
      end
   end
   always_comb
   begin
      got_a = hi_a_reg;
      got_b = hi_b_reg;
      if (mux_active)
      begin
         got_a = hi_b_reg;
         got_b = lo_b_reg;
      end
      else if (ddr_active)
      begin
         got_a = weave(hi_a_reg[5:0], lo_a_reg[5:0]);
         got_b = weave(hi_b_reg[5:0], lo_b_reg[5:0]);
      end
   end
endmodule
`default_nettype wire

// ==== test/aoic_testbench.sv ====
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic reset_pin = 1'b1;
   logic serial_select_pin = 1'b1;
   logic serial_clock_pin = 1'b1;
   logic serial_data_in_pin = 1'b0;
   logic power_ctl_pin_one = 1'b0;
   logic power_ctl_pin_two = 1'b0;
   logic power_ctl_pin_three = 1'b0;
   logic [11:0] chan_a_sample = 12'h000;
   logic [11:0] chan_b_sample = 12'h000;
   logic sample_valid = 1'b0;
   logic slow = 1'b0;
   logic sample_ready, rx_ready, out_clock_positive, out_clock_single, word_fresh;
   logic ddr_active, mux_active, global_power_down, low_speed_mode, high_speed_mode;
   logic hf_input_chan_a, hf_input_chan_b, got_valid;
   logic [1:0] best_performance_bits;
   logic [11:0] chan_a_out_bus, chan_a_out_oe, chan_b_out_bus, chan_b_out_oe, got_a, got_b;
   logic [23:0] expq[$];
   logic [23:0] exp_w;
   int seed = 32'hf4d3ad37;
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   logic [2:0] pin_codes[4] = '{3'h7, 3'h4, 3'h5, 3'h0};
   logic [2:0] pin_exp[4] = '{3'h4, 3'h2, 3'h0, 3'h1};
   logic [7:0] reg_a[9] = '{8'h03, 8'h02, 8'hd5, 8'hd7, 8'hdb, 8'hdb, 8'h77, 8'h4a, 8'h58};
   logic [7:0] reg_d[9] = '{8'h03, 8'h40, 8'h18, 8'h0c, 8'h1f, 8'h20, 8'hff, 8'h01, 8'h01};
   logic [2:0] reg_e[9] = '{3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h7, 3'h7, 3'h7, 3'h7};
   aoic_top dut_u (.mclk, .rst_n, .reset_pin, .serial_select_pin, .serial_clock_pin,
      .serial_data_in_pin, .power_ctl_pin_one, .power_ctl_pin_two, .power_ctl_pin_three,
      .chan_a_sample, .chan_b_sample, .sample_valid, .sample_ready, .rx_ready, .chan_a_out_bus,
      .chan_a_out_oe, .chan_b_out_bus, .chan_b_out_oe, .out_clock_positive, .out_clock_single,
      .word_fresh, .ddr_active, .mux_active, .global_power_down, .low_speed_mode,
      .best_performance_bits, .hf_input_chan_a, .hf_input_chan_b, .high_speed_mode);
   aoic_rx_model rx_u (.mclk, .rst_n, .slow, .rx_ready, .word_fresh, .ddr_active, .mux_active,
      .out_clock_positive, .out_clock_single, .chan_a_out_bus, .chan_b_out_bus, .got_valid,
      .got_a, .got_b);
   always #5 mclk = !mclk;
   task automatic test_done();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk_flag(input logic [2:0] got, input logic [2:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t flags %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pair(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t word pair %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ser_write(input logic [7:0] addr, input logic [7:0] data);
      logic [15:0] frame;
      frame = {addr, data};
      serial_select_pin <= 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         serial_data_in_pin <= frame[i];
         serial_clock_pin <= 1'b1;
         repeat (4) @(posedge mclk);
         serial_clock_pin <= 1'b0;
         repeat (4) @(posedge mclk);
      end
      serial_select_pin <= 1'b1;
      serial_data_in_pin <= !frame[0];
      repeat (8) @(posedge mclk);
   endtask
   task automatic stream(input int n);
      while (n > 0)
      begin
         @(posedge mclk);
         if (sample_valid && sample_ready)
         begin
            expq.push_back({chan_a_sample, chan_b_sample});
            n--;
         end
         // Words only change once the offered pair was taken
         if (!sample_valid || sample_ready)
         begin
            chan_a_sample <= 12'($random(seed));
            chan_b_sample <= 12'($random(seed));
            sample_valid <= (n > 0);
         end
      end
      for (int k = 0; k < 400 && expq.size() > 0; k++)
         @(posedge mclk);
      chk_flag({2'h0, expq.size() == 0}, 3'h1);
   endtask
   always @(posedge mclk)
   begin
      if (got_valid === 1'b1)
      begin
         exp_w = (expq.size() > 0) ? expq.pop_front() : 24'hxxxxxx;
         chk_pair({got_a, got_b}, exp_w);
      end
   end
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         errors++;
         test_done();
      end
   end
   initial
   begin
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (12) @(posedge mclk);
      ser_write(8'h03, 8'h03);
      chk_flag({1'b0, best_performance_bits}, 3'h0);
      chk_flag({1'b0, ddr_active, low_speed_mode}, 3'h2);
      serial_clock_pin <= 1'b1;
      serial_select_pin <= 1'b0;
      repeat (12) @(posedge mclk);
      chk_flag({1'b0, ddr_active, low_speed_mode}, 3'h1);
      foreach (pin_codes[i])
      begin
         {power_ctl_pin_one, power_ctl_pin_two, power_ctl_pin_three} <= pin_codes[i];
         repeat (12) @(posedge mclk);
         chk_flag({mux_active, global_power_down, |chan_a_out_oe}, pin_exp[i]);
      end
      reset_pin <= 1'b0;
      serial_select_pin <= 1'b1;
      serial_clock_pin <= 1'b0;
      repeat (6) @(posedge mclk);
      foreach (reg_a[i])
      begin
         ser_write(reg_a[i], reg_d[i]);
         chk_flag({best_performance_bits, high_speed_mode}, reg_e[i]);
      end
      chk_flag({1'b0, hf_input_chan_a, hf_input_chan_b}, 3'h3);
      slow <= 1'b1;
      stream(24);
      ser_write(aoic_pkg::ADDR_OUTPUT_CFG, 8'h01);
      chk_flag({1'b0, ddr_active, mux_active}, 3'h2);
      stream(24);
      ser_write(aoic_pkg::ADDR_OUTPUT_CFG, 8'h00);
      ser_write(aoic_pkg::ADDR_POWER_MODE, {5'h00, aoic_pkg::PMODE_MUX});
      chk_flag({1'b0, ddr_active, mux_active}, 3'h1);
      stream(24);
      ser_write(8'h00, 8'h02);
      chk_flag({best_performance_bits, mux_active}, 3'h0);
      chk_flag({1'b0, hf_input_chan_a, hf_input_chan_b}, 3'h0);
      ser_write(8'h03, 8'h03);
      chk_flag({best_performance_bits, high_speed_mode}, 3'h6);
      reset_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      reset_pin <= 1'b0;
      repeat (8) @(posedge mclk);
      chk_flag({best_performance_bits, high_speed_mode}, 3'h0);
      test_done();
   end
endmodule
`default_nettype wire
